// *** design/cvpf_defs.svh ***
// Purpose: Constants of the compact voice payload framer
// Assumes: Included by the package and by the top design module
// Notes: Payload sizes are in bits
`ifndef CVPF_DEFS_SVH
`define CVPF_DEFS_SVH
`define CVPF_SIZE_W 12
`define CVPF_MR_NONE 3'h7
`define CVPF_LEG_MODES 9
`define CVPF_LEG_PAD_BYTE 8
`define CVPF_HDR_BIT 7
// Native sizes, silence descriptor first, special 56-bit case second
`define CVPF_N_SID 12'h030
`define CVPF_N_2K8 12'h038
`define CVPF_N_7K2 12'h090
`define CVPF_N_8K0 12'h0A0
`define CVPF_N_9K6 12'h0C0
`define CVPF_N_13K2 12'h108
`define CVPF_N_16K4 12'h148
`define CVPF_N_24K4 12'h1E8
`define CVPF_N_32K 12'h280
`define CVPF_N_48K 12'h3C0
`define CVPF_N_64K 12'h500
`define CVPF_N_96K 12'h780
`define CVPF_N_128K 12'hA00
// Legacy-interoperable payload sizes, 6.6 up to 23.85
`define CVPF_L_6K6 12'h088
`define CVPF_L_8K85 12'h0B8
`define CVPF_L_12K65 12'h100
`define CVPF_L_14K25 12'h120
`define CVPF_L_15K85 12'h140
`define CVPF_L_18K25 12'h170
`define CVPF_L_19K85 12'h190
`define CVPF_L_23K05 12'h1D0
`define CVPF_L_23K85 12'h1E0
// Speech bits per legacy frame
`define CVPF_K_6K6 12'h084
`define CVPF_K_8K85 12'h0B1
`define CVPF_K_12K65 12'h0FD
`define CVPF_K_14K25 12'h11D
`define CVPF_K_15K85 12'h13D
`define CVPF_K_18K25 12'h16D
`define CVPF_K_19K85 12'h18D
`define CVPF_K_23K05 12'h1CD
`define CVPF_K_23K85 12'h1DD
// Frame period, clock rate and reset mode cap
`define CVPF_FRAME_MS 20
`define CVPF_CLK_HZ 20000000
`define CVPF_RST_REQ_IDX 4'h8
`endif

// *** design/cvpf_pack.sv ***
// Purpose: Serial packer of one compact payload
// Assumes: Speech bits arrive as d(0) first
// Notes: Output bit stream is registered
`timescale 1ns/1ps
`default_nettype none
module cvpf_pack import cvpf_pkg::*; (
    input wire logic clk,
    input wire logic rst_n,
    cvpf_pack_if.pk pif,
    input wire logic sb_valid,
    input wire logic sb_data,
    output logic sb_ready,
    output logic pb_valid,
    output logic pb_data,
    output logic pb_last,
    input wire logic pb_ready
);
    cvpf_pk_state_t st_reg, st_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [2:0] code_reg, code_next;
    logic [2:0] pad_reg, pad_next;
    logic nat_reg, nat_next;
    logic d0_reg, d0_next;
    logic ov_reg, ov_next;
    logic od_reg, od_next;
    logic ol_reg, ol_next;
    logic can_load;

    assign can_load = !ov_reg || pb_ready;
    assign pif.busy = (st_reg != PK_IDLE);
    assign pb_valid = ov_reg;
    assign pb_data = od_reg;
    assign pb_last = ol_reg;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        code_next = code_reg;
        pad_next = pad_reg;
        nat_next = nat_reg;
        d0_next = d0_reg;
        ov_next = ov_reg && !pb_ready;
        od_next = od_reg;
        ol_next = ol_reg;
        sb_ready = 1'b0;
        case (st_reg)
            PK_IDLE: begin
                if (pif.start) begin
                    code_next = pif.code;
                    pad_next = pif.npad;
                    nat_next = !pif.legacy;
                    cnt_next = pif.legacy ? 12'h003 : pif.nbits;
                    st_next = pif.legacy ? PK_HDR : PK_BODY;
                end
            end
            PK_HDR: begin
                if (can_load) begin
                    ov_next = 1'b1;
                    od_next = code_reg[2];
                    ol_next = 1'b0;
                    code_next = {code_reg[1:0], 1'b0};
                    cnt_next = cnt_reg - 12'h001;
                    if (cnt_reg == 12'h001) begin
                        st_next = PK_GRAB;
                        cnt_next = pif.nbits - 12'h001;
                    end
                end
            end
            PK_GRAB: begin
                sb_ready = 1'b1;
                if (sb_valid) begin
                    d0_next = sb_data;
                    st_next = PK_BODY;
                end
            end
            PK_BODY: begin
                sb_ready = can_load;
                if (can_load && sb_valid) begin
                    ov_next = 1'b1;
                    od_next = sb_data;
                    ol_next = nat_reg && (cnt_reg == 12'h001);
                    cnt_next = cnt_reg - 12'h001;
                    if (cnt_reg == 12'h001) begin
                        st_next = nat_reg ? PK_IDLE : PK_TAIL;
                    end
                end
            end
            PK_TAIL: begin
                if (can_load) begin
                    ov_next = 1'b1;
                    od_next = d0_reg;
                    ol_next = (pad_reg == 3'h0);
                    st_next = (pad_reg == 3'h0) ? PK_IDLE : PK_PAD;
                end
            end
            PK_PAD: begin
                if (can_load) begin
                    ov_next = 1'b1;
                    od_next = 1'b0;
                    ol_next = (pad_reg == 3'h1);
                    pad_next = pad_reg - 3'h1;
                    if (pad_reg == 3'h1) begin
                        st_next = PK_IDLE;
                    end
                end
            end
            default: st_next = PK_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= PK_IDLE;
            cnt_reg <= 12'h000;
            code_reg <= 3'h0;
            pad_reg <= 3'h0;
            nat_reg <= 1'b0;
            d0_reg <= 1'b0;
            ov_reg <= 1'b0;
            od_reg <= 1'b0;
            ol_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            code_reg <= code_next;
            pad_reg <= pad_next;
            nat_reg <= nat_next;
            d0_reg <= d0_next;
            ov_reg <= ov_next;
            od_reg <= od_next;
            ol_reg <= ol_next;
        end
    end
endmodule // cvpf_pack
`default_nettype wire

// *** design/cvpf_pack_if.sv ***
// Purpose: Frame start and shape from control to the bit packer
// Assumes: One clock domain
// Notes: start is a one-cycle pulse taken only while busy is low
`timescale 1ns/1ps
`default_nettype none
interface cvpf_pack_if;
    logic start;
    logic legacy;
    logic [2:0] code;
    logic [11:0] nbits;
    logic [2:0] npad;
    logic busy;
    modport ctl (output start, output legacy, output code,
        output nbits, output npad, input busy);
    modport pk (input start, input legacy, input code, input nbits,
        input npad, output busy);
endinterface
`default_nettype wire

// *** design/cvpf_pkg.sv ***
// Purpose: Types and the shared legacy speech-bit decoder of the payload framer
// Assumes: cvpf_defs.svh holds the numbers
// Notes: Legacy index 0..8 runs from 6.6 to 23.85
`include "cvpf_defs.svh"
package cvpf_pkg;
    typedef enum logic [1:0] {FMT_NONE, FMT_NATIVE, FMT_LEGACY,
        FMT_HDRFULL} cvpf_fmt_t;
    typedef enum logic [2:0] {PK_IDLE, PK_HDR, PK_GRAB, PK_BODY,
        PK_TAIL, PK_PAD} cvpf_pk_state_t;

    function automatic logic [11:0] cvpf_leg_k(input logic [3:0] idx);
        case (idx)
            4'h0: cvpf_leg_k = `CVPF_K_6K6;
            4'h1: cvpf_leg_k = `CVPF_K_8K85;
            4'h2: cvpf_leg_k = `CVPF_K_12K65;
            4'h3: cvpf_leg_k = `CVPF_K_14K25;
            4'h4: cvpf_leg_k = `CVPF_K_15K85;
            4'h5: cvpf_leg_k = `CVPF_K_18K25;
            4'h6: cvpf_leg_k = `CVPF_K_19K85;
            4'h7: cvpf_leg_k = `CVPF_K_23K05;
            default: cvpf_leg_k = `CVPF_K_23K85;
        endcase
    endfunction
endpackage

// *** design/cvpf_top.sv ***
// Purpose: Compact voice payload classify, mode request control, packing
// Assumes: One clock; payload size and first byte given per packet
// Notes: Header-full parsing and building live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "cvpf_defs.svh"
module cvpf_top import cvpf_pkg::*; #(
    parameter int FRAME_CYCLES = `CVPF_FRAME_MS * (`CVPF_CLK_HZ / 1000)
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic RX_VALID,
    input wire logic [11:0] RX_SIZE,
    input wire logic [7:0] RX_HEAD,
    input wire logic RX_CONVERTED,
    input wire logic RX_Q_OK,
    output logic [1:0] RX_FMT,
    output logic [3:0] RX_RATE,
    output logic RX_MR_VALID,
    output logic [2:0] RX_MR_CODE,
    output logic RX_DROP,
    input wire logic [8:0] NEG_SET,
    input wire logic HF_ONLY,
    input wire logic REQ_VALID,
    input wire logic REQ_NATIVE,
    input wire logic [3:0] REQ_IDX,
    output logic [2:0] REQ_CODE,
    output logic REQ_HF,
    input wire logic TX_ENABLE,
    input wire logic TX_SID,
    input wire logic [3:0] TX_NATIVE_IDX,
    output logic TX_LEGACY,
    output logic [3:0] TX_MODE_IDX,
    output logic FRAME_TICK,
    output logic TX_HF_FRAME,
    input wire logic SB_VALID,
    input wire logic SB_DATA,
    output logic SB_READY,
    output logic PB_VALID,
    output logic PB_DATA,
    output logic PB_LAST,
    input wire logic PB_READY
);
    localparam int FRAME_CNT = (FRAME_CYCLES < 1) ? 1 : FRAME_CYCLES;

    // Elaboration check: a shorter period leaves no room to start a frame
    if (FRAME_CYCLES < 2) begin : g_bad_period
        $error("FRAME_CYCLES must be at least 2");
    end

    // Native size to rate index, 4'hF when not a native size
    function automatic logic [3:0] nat_idx(input logic [11:0] sz);
        case (sz)
            `CVPF_N_SID: nat_idx = 4'h0;
            `CVPF_N_2K8: nat_idx = 4'h1;
            `CVPF_N_7K2: nat_idx = 4'h2;
            `CVPF_N_8K0: nat_idx = 4'h3;
            `CVPF_N_9K6: nat_idx = 4'h4;
            `CVPF_N_13K2: nat_idx = 4'h5;
            `CVPF_N_16K4: nat_idx = 4'h6;
            `CVPF_N_24K4: nat_idx = 4'h7;
            `CVPF_N_32K: nat_idx = 4'h8;
            `CVPF_N_48K: nat_idx = 4'h9;
            `CVPF_N_64K: nat_idx = 4'hA;
            `CVPF_N_96K: nat_idx = 4'hB;
            `CVPF_N_128K: nat_idx = 4'hC;
            default: nat_idx = 4'hF;
        endcase
    endfunction

    function automatic logic [3:0] leg_idx(input logic [11:0] sz);
        case (sz)
            `CVPF_L_6K6: leg_idx = 4'h0;
            `CVPF_L_8K85: leg_idx = 4'h1;
            `CVPF_L_12K65: leg_idx = 4'h2;
            `CVPF_L_14K25: leg_idx = 4'h3;
            `CVPF_L_15K85: leg_idx = 4'h4;
            `CVPF_L_18K25: leg_idx = 4'h5;
            `CVPF_L_19K85: leg_idx = 4'h6;
            `CVPF_L_23K05: leg_idx = 4'h7;
            `CVPF_L_23K85: leg_idx = 4'h8;
            default: leg_idx = 4'hF;
        endcase
    endfunction

    function automatic logic [3:0] code_to_idx(input logic [2:0] c);
        case (c)
            3'h0: code_to_idx = 4'h0;
            3'h1: code_to_idx = 4'h1;
            3'h2: code_to_idx = 4'h2;
            3'h3: code_to_idx = 4'h4;
            3'h4: code_to_idx = 4'h5;
            3'h5: code_to_idx = 4'h7;
            3'h6: code_to_idx = 4'h8;
            default: code_to_idx = 4'hF;
        endcase
    endfunction

    function automatic logic [2:0] idx_to_code(input logic [3:0] i);
        case (i)
            4'h0: idx_to_code = 3'h0;
            4'h1: idx_to_code = 3'h1;
            4'h2: idx_to_code = 3'h2;
            4'h4: idx_to_code = 3'h3;
            4'h5: idx_to_code = 3'h4;
            4'h7: idx_to_code = 3'h5;
            4'h8: idx_to_code = 3'h6;
            default: idx_to_code = `CVPF_MR_NONE;
        endcase
    endfunction

    // Receive classification, all combinational in the accept cycle
    logic [3:0] rx_nat, rx_leg, rx_req_idx;
    logic rx_damaged, rx_req_ok;

    always_comb begin
        rx_nat = nat_idx(RX_SIZE);
        rx_leg = leg_idx(RX_SIZE);
        rx_damaged = RX_CONVERTED && !RX_Q_OK;
        RX_FMT = FMT_NONE;
        RX_RATE = 4'h0;
        RX_MR_CODE = `CVPF_MR_NONE;
        RX_DROP = 1'b0;
        if (RX_VALID) begin
            if (rx_damaged) begin
                RX_DROP = 1'b1;
            end else if (rx_nat == 4'h1) begin
                // set top bit marks a request byte
                RX_FMT = RX_HEAD[`CVPF_HDR_BIT] ? FMT_HDRFULL : FMT_NATIVE;
                RX_RATE = RX_HEAD[`CVPF_HDR_BIT] ? 4'h0 : rx_nat;
            end else if (rx_nat != 4'hF) begin
                RX_FMT = FMT_NATIVE;
                RX_RATE = rx_nat;
            end else if (rx_leg != 4'hF) begin
                RX_FMT = FMT_LEGACY;
                RX_RATE = rx_leg;
                RX_MR_CODE = RX_HEAD[7:5];
            end else begin
                RX_FMT = FMT_HDRFULL;
            end
        end
        rx_req_idx = code_to_idx(RX_MR_CODE);
        rx_req_ok = (RX_FMT == FMT_LEGACY) && (rx_req_idx != 4'hF) &&
            NEG_SET[rx_req_idx[3:0]];
        RX_MR_VALID = rx_req_ok;
    end

    // Sender mode state
    logic leg_reg, leg_next;
    logic [3:0] cap_reg, cap_next;
    logic [3:0] mode_reg, mode_next;

    always_comb begin
        leg_next = leg_reg;
        cap_next = cap_reg;
        mode_next = mode_reg;
        if (rx_req_ok) begin
            leg_next = 1'b1;
            cap_next = rx_req_idx;
        end
        // highest allowed mode not above cap
        for (int i = 0; i < `CVPF_LEG_MODES; i++) begin
            if (NEG_SET[i] && (4'(i) <= cap_next)) begin
                mode_next = 4'(i);
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            leg_reg <= 1'b0;
            cap_reg <= `CVPF_RST_REQ_IDX;
            mode_reg <= 4'h0;
        end else begin
            leg_reg <= leg_next;
            cap_reg <= cap_next;
            mode_reg <= mode_next;
        end
    end

    assign TX_LEGACY = leg_reg;
    assign TX_MODE_IDX = mode_reg;

    // Outgoing request code
    logic [2:0] rq_code_reg, rq_code_next;
    logic rq_hf_reg, rq_hf_next;
    logic [3:0] rq_tgt;

    always_comb begin
        rq_code_next = rq_code_reg;
        rq_hf_next = rq_hf_reg;
        rq_tgt = REQ_IDX;
        if (REQ_VALID) begin
            rq_hf_next = 1'b0;
            rq_code_next = `CVPF_MR_NONE;
            if (REQ_NATIVE) begin
                rq_hf_next = 1'b1;
            end else begin
                for (int i = 0; i < `CVPF_LEG_MODES; i++) begin
                    if (NEG_SET[i] && (4'(i) <= rq_tgt) &&
                            (idx_to_code(4'(i)) != `CVPF_MR_NONE)) begin
                        rq_code_next = idx_to_code(4'(i));
                    end
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rq_code_reg <= `CVPF_MR_NONE;
            rq_hf_reg <= 1'b0;
        end else begin
            rq_code_reg <= rq_code_next;
            rq_hf_reg <= rq_hf_next;
        end
    end

    assign REQ_CODE = rq_code_reg;
    assign REQ_HF = rq_hf_reg;

    logic [31:0] fcnt_reg, fcnt_next;
    logic tick_reg, tick_next;
    logic hf_reg, hf_next;
    cvpf_pack_if pif ();

    always_comb begin
        fcnt_next = fcnt_reg + 32'h1;
        tick_next = 1'b0;
        hf_next = 1'b0;
        pif.start = 1'b0;
        pif.legacy = leg_reg;
        pif.code = rq_code_reg;
        pif.nbits = leg_reg ? cvpf_leg_k(mode_reg) : 12'h000;
        pif.npad = 3'h0;
        if (!leg_reg) begin
            case (TX_NATIVE_IDX)
                4'h0: pif.nbits = `CVPF_N_SID;
                4'h1: pif.nbits = `CVPF_N_2K8;
                4'h2: pif.nbits = `CVPF_N_7K2;
                4'h3: pif.nbits = `CVPF_N_8K0;
                4'h4: pif.nbits = `CVPF_N_9K6;
                4'h5: pif.nbits = `CVPF_N_13K2;
                4'h6: pif.nbits = `CVPF_N_16K4;
                4'h7: pif.nbits = `CVPF_N_24K4;
                4'h8: pif.nbits = `CVPF_N_32K;
                4'h9: pif.nbits = `CVPF_N_48K;
                4'hA: pif.nbits = `CVPF_N_64K;
                4'hB: pif.nbits = `CVPF_N_96K;
                default: pif.nbits = `CVPF_N_128K;
            endcase
        end else begin
            // pad the 3 header bits plus the speech bits to whole bytes
            pif.npad = 3'(12'h008 - ((pif.nbits + 12'h003) & 12'h007));
            pif.npad = (pif.npad == 3'h0) ? 3'h0 : pif.npad;
        end
        if (fcnt_reg == 32'(FRAME_CNT - 1)) begin
            fcnt_next = 32'h0;
            tick_next = 1'b1;
            if (TX_ENABLE) begin
                if (HF_ONLY || (leg_reg && TX_SID) || pif.busy) begin
                    hf_next = 1'b1;
                end else begin
                    pif.start = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fcnt_reg <= 32'h0;
            tick_reg <= 1'b0;
            hf_reg <= 1'b0;
        end else begin
            fcnt_reg <= fcnt_next;
            tick_reg <= tick_next;
            hf_reg <= hf_next;
        end
    end

    assign FRAME_TICK = tick_reg;
    assign TX_HF_FRAME = hf_reg;

    cvpf_pack u_pack (
        .clk(SYS_CLK),
        .rst_n(RSTN),
        .pif(pif.pk),
        .sb_valid(SB_VALID),
        .sb_data(SB_DATA),
        .sb_ready(SB_READY),
        .pb_valid(PB_VALID),
        .pb_data(PB_DATA),
        .pb_last(PB_LAST),
        .pb_ready(PB_READY)
    );
endmodule // cvpf_top
`default_nettype wire

// *** verif/compact_voice_payload_framer_test.sv ***
// Purpose: Self-checking bench of the payload framer
// Assumes: Frame period cut to 600 cycles
// Notes: Legacy mode is sticky, so native frames go first
`timescale 1ns/1ps
`default_nettype none
module compact_voice_payload_framer_test import cvpf_pkg::*;;
    logic SYS_CLK, RSTN, RX_VALID, RX_CONVERTED, RX_Q_OK, HF_ONLY, leg;
    logic REQ_VALID, REQ_NATIVE, TX_ENABLE, TX_SID, SB_VALID, SB_DATA;
    logic SB_READY, PB_VALID, PB_DATA, PB_LAST, PB_READY, RX_MR_VALID;
    logic RX_DROP, REQ_HF, TX_LEGACY, FRAME_TICK, TX_HF_FRAME;
    logic [11:0] RX_SIZE;
    logic [8:0] NEG_SET, s;
    logic [7:0] RX_HEAD;
    logic [3:0] REQ_IDX, TX_NATIVE_IDX, RX_RATE, TX_MODE_IDX, mode, t, cp;
    logic [2:0] RX_MR_CODE, REQ_CODE, c;
    logic [1:0] RX_FMT;
    int fail_count, samples_checked;
    logic [11:0] nsz [13] = '{12'h030, 12'h038, 12'h090, 12'h0A0,
        12'h0C0, 12'h108, 12'h148, 12'h1E8, 12'h280, 12'h3C0, 12'h500,
        12'h780, 12'hA00};
    logic [11:0] lsz [9] = '{12'h088, 12'h0B8, 12'h100, 12'h120,
        12'h140, 12'h170, 12'h190, 12'h1D0, 12'h1E0};
    always #25 SYS_CLK = ~SYS_CLK;
    cvpf_top #(.FRAME_CYCLES(600)) dut_u (.SYS_CLK, .RSTN, .RX_VALID,
        .RX_SIZE, .RX_HEAD, .RX_CONVERTED, .RX_Q_OK, .RX_FMT, .RX_RATE,
        .RX_MR_VALID, .RX_MR_CODE, .RX_DROP, .NEG_SET, .HF_ONLY,
        .REQ_VALID, .REQ_NATIVE, .REQ_IDX, .REQ_CODE, .REQ_HF, .TX_ENABLE,
        .TX_SID, .TX_NATIVE_IDX, .TX_LEGACY, .TX_MODE_IDX, .FRAME_TICK,
        .TX_HF_FRAME, .SB_VALID, .SB_DATA, .SB_READY, .PB_VALID,
        .PB_DATA, .PB_LAST, .PB_READY);
    cvpf_far_end far_u (.clk(SYS_CLK), .rst_n(RSTN),
        .frame_tick(FRAME_TICK), .sb_valid(SB_VALID), .sb_data(SB_DATA),
        .sb_ready(SB_READY), .pb_valid(PB_VALID), .pb_data(PB_DATA),
        .pb_last(PB_LAST), .pb_ready(PB_READY));
    task automatic chk(input logic ok, input string m);
        samples_checked++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Combinational answers are read 5 ns after the falling edge
    task automatic rx(input logic [11:0] sz, input logic [7:0] hd,
        input logic cv);
        @(negedge SYS_CLK);
        RX_VALID = 1'b1;
        RX_SIZE = sz;
        RX_HEAD = hd;
        RX_CONVERTED = cv;
        RX_Q_OK = !cv;
        #5;
    endtask
    task automatic wev(input logic frm);
        int n;
        n = far_u.frames;
        for (int i = 0; i < 2000; i++) begin
            @(negedge SYS_CLK);
            if (frm ? far_u.frames != n : TX_HF_FRAME === 1'b1)
                return;
        end
        chk(1'b0, "wait timed out");
        summarize();
    endtask
    task automatic fchk(input int n, input logic lg);
        int bad;
        bad = 0;
        for (int k = 0; k < n; k++)
            bad += far_u.bits[k] !== (!lg ? ~^(k & 32'h15) : k < 3 ? 1'b1
                : k < n - 2 ? ~^((k - 2) & 32'h15) : k == n - 2);
        chk(far_u.got_n === 12'(n) && bad == 0, "frame bits");
    endtask
    initial begin
        {SYS_CLK, RSTN, RX_VALID, RX_CONVERTED, HF_ONLY, REQ_VALID} = '0;
        {REQ_NATIVE, TX_ENABLE, TX_SID, leg, mode} = '0;
        {RX_SIZE, RX_HEAD, REQ_IDX, TX_NATIVE_IDX} = '0;
        RX_Q_OK = 1'b1;
        NEG_SET = 9'h1FF;
        fail_count = 0;
        samples_checked = 0;
        void'($urandom(32'h2B51));
        repeat (3) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        RSTN = 1'b1;
        chk(REQ_CODE === 3'h7 && TX_LEGACY === 1'b0, "reset");
        for (int i = 0; i < 13; i++) begin
            rx(nsz[i], 8'($urandom) & 8'h7F, 1'b0);
            chk(RX_FMT === FMT_NATIVE && RX_RATE === 4'(i), "n");
        end
        for (int i = 0; i < 9; i++) begin
            rx(lsz[i], 8'($urandom) | 8'hE0, 1'b0);
            chk(RX_FMT === FMT_LEGACY && RX_RATE === 4'(i), "l");
            chk(RX_MR_CODE === 3'h7 && !RX_MR_VALID, "none");
        end
        rx(12'h038, 8'h80, 1'b0);
        chk(RX_FMT === FMT_HDRFULL, "56 top one");
        rx(12'h064, 8'h00, 1'b0);
        chk(RX_FMT === FMT_HDRFULL, "unlisted size");
        rx(12'h088, 8'h00, 1'b1);
        chk(RX_DROP === 1'b1 && RX_FMT === FMT_NONE, "damaged");
        @(negedge SYS_CLK);
        RX_VALID = 1'b0;
        for (int i = 0; i < 10; i++) begin
            s = 9'($urandom);
            NEG_SET = s;
            c = 3'h7;
            // Expressible request at or below the wanted mode
            for (int j = 0; j <= i && i < 9; j++)
                if (s[j] && j != 3 && j != 6)
                    c = 3'(j - (j > 3) - (j > 6));
            REQ_VALID = 1'b1;
            REQ_NATIVE = i == 9;
            REQ_IDX = 4'(i);
            @(negedge SYS_CLK);
            chk(REQ_CODE === c && REQ_HF === (i == 9), "req");
        end
        REQ_VALID = 1'b0;
        NEG_SET = 9'h1FF;
        TX_NATIVE_IDX = 4'h2;
        TX_ENABLE = 1'b1;
        wev(1'b1);
        fchk(nsz[2], 1'b0);
        HF_ONLY = 1'b1;
        wev(1'b0);
        chk(SB_READY === 1'b0 && PB_VALID === 1'b0, "hf only");
        chk(FRAME_TICK === 1'b1, "tick");
        TX_ENABLE = 1'b0;
        HF_ONLY = 1'b0;
        s = (9'($urandom) & 9'h1EF) | 9'h001;
        NEG_SET = s;
        cp = 4'h8;
        for (int i = 0; i < 9; i++) begin
            c = i == 0 ? 3'h3 : i == 8 ? 3'h0 : 3'($urandom % 7);
            rx(12'h088, {c, 5'h00}, 1'b0);
            t = {1'b0, c} + (c > 3'h2) + (c > 3'h4);
            chk(RX_MR_VALID === s[t], "request kept");
            // Highest negotiated mode not above the standing request
            cp = s[t] ? t : cp;
            for (int j = 0; j <= cp; j++)
                if (s[j])
                    mode = 4'(j);
            leg = leg | s[t];
            @(negedge SYS_CLK);
            chk(TX_LEGACY === leg && TX_MODE_IDX === mode, "m");
        end
        RX_VALID = 1'b0;
        TX_ENABLE = 1'b1;
        wev(1'b1);
        fchk(136, 1'b1);
        TX_SID = 1'b1;
        wev(1'b0);
        chk(SB_READY === 1'b0 && PB_VALID === 1'b0, "sid");
        summarize();
    end
endmodule // compact_voice_payload_framer_test
`default_nettype wire

// *** verif/cvpf_far_end.sv ***
// Purpose: Far end: speech bit source and payload bit sink
// Assumes: Handshakes taken on the rising edge
// Notes: Both sides stall at random
`timescale 1ns/1ps
`default_nettype none
module cvpf_far_end (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic frame_tick,
    output logic sb_valid,
    output logic sb_data,
    input wire logic sb_ready,
    input wire logic pb_valid,
    input wire logic pb_data,
    input wire logic pb_last,
    output logic pb_ready
);
    logic [11:0] sb_n, pb_n, got_n;
    int frames;
    logic bits [4096];
    wire logic pat = ~(sb_n[0] ^ sb_n[2] ^ sb_n[4]);
    // Idle line flips so a stale bit never passes for data
    assign sb_data = sb_valid ? pat : ~pat;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {sb_n, pb_n, got_n, sb_valid, pb_ready} <= '0;
            frames <= 0;
        end else begin
            sb_valid <= (sb_valid && !sb_ready) || ($urandom % 4 != 0);
            pb_ready <= $urandom % 4 != 0;
            sb_n <= (frame_tick ? 12'h000 : sb_n) + (sb_valid && sb_ready);
            if (pb_valid && pb_ready) begin
                bits[pb_n] <= pb_data;
                pb_n <= pb_last ? 12'h000 : pb_n + 12'h001;
                got_n <= pb_last ? pb_n + 12'h001 : got_n;
                frames <= frames + pb_last;
            end
        end
    end
endmodule // cvpf_far_end
`default_nettype wire

// *** verif/cvpf_top_assertions.sv ***
// Purpose: Port checks of the payload framer
// Assumes: Bound into cvpf_top, one clock
// Notes: Mode state is seen one edge after accept
`timescale 1ns/1ps
`default_nettype none
module cvpf_top_assertions (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic RX_VALID,
    input wire logic [11:0] RX_SIZE,
    input wire logic [7:0] RX_HEAD,
    input wire logic RX_CONVERTED,
    input wire logic RX_Q_OK,
    input wire logic [1:0] RX_FMT,
    input wire logic RX_MR_VALID,
    input wire logic [2:0] RX_MR_CODE,
    input wire logic RX_DROP,
    input wire logic [8:0] NEG_SET,
    input wire logic REQ_VALID,
    input wire logic REQ_NATIVE,
    input wire logic [2:0] REQ_CODE,
    input wire logic REQ_HF,
    input wire logic TX_LEGACY,
    input wire logic [3:0] TX_MODE_IDX,
    input wire logic PB_VALID,
    input wire logic PB_DATA,
    input wire logic PB_READY
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    wire logic ok = RX_VALID && !(RX_CONVERTED && !RX_Q_OK);
    // Code to legacy index: codes skip indices 3 and 6
    wire logic [3:0] cap = {1'b0, RX_MR_CODE} + (RX_MR_CODE > 3'h2)
        + (RX_MR_CODE > 3'h4);
    mr_none_a: assert property (
        RX_VALID && RX_FMT != 2'h2 |-> RX_MR_CODE == 3'h7)
        else $error("request code off legacy");
    mr_valid_a: assert property (
        RX_MR_VALID |-> RX_MR_CODE != 3'h7 && NEG_SET[cap])
        else $error("request outside set");
    size_56_a: assert property (
        ok && RX_SIZE == 12'h038 |-> RX_FMT == (RX_HEAD[7] ? 2'h3 : 2'h1))
        else $error("56 bit split wrong");
    drop_bad_a: assert property (
        RX_VALID && RX_CONVERTED && !RX_Q_OK |-> RX_DROP && !RX_MR_VALID)
        else $error("damaged frame kept");
    req_native_a: assert property (
        REQ_VALID && REQ_NATIVE |=> REQ_CODE == 3'h7 && REQ_HF)
        else $error("native request in field");
    go_legacy_a: assert property (
        ok && RX_MR_VALID |=> TX_LEGACY)
        else $error("no legacy switch");
    cap_mode_a: assert property (
        ok && RX_MR_VALID |=> TX_MODE_IDX == $past(cap))
        else $error("mode above request");
    pb_hold_a: assert property (
        PB_VALID && !PB_READY |=> PB_VALID && $stable(PB_DATA))
        else $error("payload bit not held");
endmodule // cvpf_top_assertions
bind cvpf_top cvpf_top_assertions chk_u (.SYS_CLK, .RSTN, .RX_VALID,
    .RX_SIZE, .RX_HEAD, .RX_CONVERTED, .RX_Q_OK, .RX_FMT, .RX_MR_VALID,
    .RX_MR_CODE, .RX_DROP, .NEG_SET, .REQ_VALID, .REQ_NATIVE, .REQ_CODE,
    .REQ_HF, .TX_LEGACY, .TX_MODE_IDX, .PB_VALID, .PB_DATA, .PB_READY);
`default_nettype wire
